/* hdl/pae_alarm_evaluator.sv */
`timescale 1ns/1ns
`include "pae_params.svh"
// Notes on behaviour
// - each channel holds its own type code
// - type code resets to upper deviation, 2
// - on and off delays, 0 to 999 s
// - alarm result drives its auxiliary output
// - code 0 keeps the output off
// - code 1: active outside deviation band
// - code 2: value exceeds set point by threshold
// - code 3: value under set point by threshold
// - code 4: active inside deviation band
// - code 5: band outside plus standby
// - codes 6, 7: deviation plus standby
// - code 8: process value above threshold
// - code 9: process value below threshold
// - codes 10, 11: absolute plus standby
// - code 12 loop break, channel zero only
// - code 13: process value change rate
// - code 14: set point above threshold
// - code 15: set point below threshold
// - code 16: manipulated variable above threshold
// - code 17: manipulated variable below threshold
// - input codes 25-29 scale analog input
// - outside-band alarms (codes 1, 5) off when hysteresis overlaps
// - heat/cool: upper on heat, lower cool
module pae_alarm_evaluator
	import pae_pkg::*;
#(
	parameter int NCH        = 2,
	parameter int W          = 16,
	parameter int SAMPLE_CYC = `PAE_SAMPLE_CYC,
	parameter int SEC_SMP    = `PAE_SAMPLES_PER_S
)(
	input  wire logic                         mclk,
	input  wire logic                         rst_n,
	input  wire logic                         ce,
	input  wire logic [NCH-1:0]               cfgTypeWr,
	input  wire pae_code_t                    cfgTypeCode,
	input  wire logic [NCH-1:0][W-1:0]        thrX,
	input  wire logic [NCH-1:0][W-1:0]        devHigh,
	input  wire logic [NCH-1:0][W-1:0]        devLow,
	input  wire logic [NCH-1:0][9:0]          onDelay,
	input  wire logic [NCH-1:0][9:0]          offDelay,
	input  wire logic [W-1:0]                 hyst,
	input  wire pae_code_t                    inputType,
	input  wire logic signed [W-1:0]          tempIn,
	input  wire logic [`PAE_FRAC_BITS-1:0]    analogIn,
	input  wire logic signed [W-1:0]          scaleLow,
	input  wire logic signed [W-1:0]          scaleHigh,
	input  wire logic [1:0]                   decimalsIn,
	input  wire logic signed [W-1:0]          set_point,
	input  wire logic signed [W-1:0]          manipulated_variable,
	input  wire logic signed [W-1:0]          coolVariable,
	input  wire logic                         heatCool,
	input  wire logic                         loop_break_alarm,
	input  wire logic [NCH-1:0]               rateTrip,
	output logic [NCH-1:0]                    auxOut,
	output logic [NCH-1:0]                    rawAlarm,
	output pae_code_t [NCH-1:0]               activeType,
	output logic signed [W-1:0]               process_value,
	output logic [1:0]                        procDecimals,
	output logic                              sampleTick
);
	localparam int SCW = $clog2(SAMPLE_CYC + 1);
	localparam int SSW = $clog2(SEC_SMP + 1);
	localparam int PW  = W + `PAE_FRAC_BITS + 2;

	// a code is taken only if defined and allowed on this channel
	function automatic logic codeOk(input pae_code_t c, input int ch);
		codeOk = (c <= `PAE_T_MV_LO) &&
			!(c == `PAE_T_LOOP_BREAK && ch != 0);
	endfunction : codeOk

	function automatic logic signed [W-1:0] clampScale(
		input logic signed [W-1:0] v);
		if (v < $signed(`PAE_SCALE_MIN)) begin
			clampScale = $signed(`PAE_SCALE_MIN);
		end else if (v > $signed(`PAE_SCALE_MAX)) begin
			clampScale = $signed(`PAE_SCALE_MAX);
		end else begin
			clampScale = v;
		end
	endfunction : clampScale

	// sampling period and one-second timebase
	logic [SCW-1:0] smpCnt_ff, nxt_smpCnt;
	logic [SSW-1:0] secCnt_ff, nxt_secCnt;
	logic           tick_ff, nxt_tick, sec_ff, nxt_sec, eval_ff, nxt_eval;

	always_comb begin
		nxt_smpCnt = smpCnt_ff + SCW'(1);
		nxt_secCnt = secCnt_ff;
		nxt_tick   = 1'b0;
		nxt_sec    = 1'b0;
		nxt_eval   = tick_ff;
		if (smpCnt_ff == SCW'(SAMPLE_CYC - 1)) begin
			nxt_smpCnt = '0;
			nxt_tick   = 1'b1;
			nxt_secCnt = secCnt_ff + SSW'(1);
			if (secCnt_ff == SSW'(SEC_SMP - 1)) begin
				nxt_secCnt = '0;
				nxt_sec    = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			smpCnt_ff <= '0;
			secCnt_ff <= '0;
			tick_ff   <= 1'b0;
			sec_ff    <= 1'b0;
			eval_ff   <= 1'b0;
		end else if (ce) begin
			smpCnt_ff <= nxt_smpCnt;
			secCnt_ff <= nxt_secCnt;
			tick_ff   <= nxt_tick;
			sec_ff    <= nxt_sec;
			eval_ff   <= nxt_eval;
		end
	end

	assign sampleTick = tick_ff;

	// input conditioning, latched once per sampling period
	logic signed [W-1:0]    procVal_ff, nxt_procVal, setPt_ff, nxt_setPt;
	logic signed [W-1:0]    manHi_ff, nxt_manHi, manLo_ff, nxt_manLo;
	logic [1:0]             dp_ff, nxt_dp;
	logic signed [W-1:0]    loC, hiC;
	logic signed [PW-1:0]   span, prod;
	logic                   analogSel;

	always_comb begin
		loC  = clampScale(scaleLow);
		hiC  = clampScale(scaleHigh);
		span = PW'(hiC) - PW'(loC);
		// full-scale input lands one count short of the high end
		prod = span * $signed({2'b00, analogIn});
		analogSel = inputType >= `PAE_IN_ANALOG_LO &&
			inputType <= `PAE_IN_ANALOG_HI;
		nxt_procVal = procVal_ff;
		nxt_setPt   = setPt_ff;
		nxt_manHi   = manHi_ff;
		nxt_manLo   = manLo_ff;
		nxt_dp      = dp_ff;
		if (tick_ff) begin
			if (analogSel) begin
				nxt_procVal = W'(PW'(loC) +
					(prod >>> `PAE_FRAC_BITS));
				nxt_dp = decimalsIn;
			end else begin
				nxt_procVal = tempIn;
				nxt_dp      = '0;
			end
			nxt_setPt = set_point;
			nxt_manHi = manipulated_variable;
			nxt_manLo = heatCool ? coolVariable : manipulated_variable;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			procVal_ff <= '0;
			setPt_ff   <= '0;
			manHi_ff   <= '0;
			manLo_ff   <= '0;
			dp_ff      <= '0;
		end else if (ce) begin
			procVal_ff <= nxt_procVal;
			setPt_ff   <= nxt_setPt;
			manHi_ff   <= nxt_manHi;
			manLo_ff   <= nxt_manLo;
			dp_ff      <= nxt_dp;
		end
	end

	assign process_value = procVal_ff;
	assign procDecimals  = dp_ff;

	// inputs moving mid-period must not reach the comparators
	AST_LATCH_HOLD: assert property (@(posedge mclk)
		disable iff (!rst_n)
		!(ce && tick_ff) |=> $stable(procVal_ff) && $stable(setPt_ff))
		else $error("latched inputs moved between samples");
	AST_TEMP_PATH: assert property (@(posedge mclk)
		disable iff (!rst_n)
		ce && tick_ff && !analogSel
		|=> procVal_ff == $past(tempIn) && dp_ff == '0)
		else $error("temperature input not latched");
	AST_HEAT_ONLY: assert property (@(posedge mclk)
		disable iff (!rst_n)
		ce && tick_ff |=> manHi_ff == $past(manipulated_variable))
		else $error("upper output alarm not on heating side");
	AST_COOL_ONLY: assert property (@(posedge mclk)
		disable iff (!rst_n)
		ce && tick_ff && heatCool |=> manLo_ff == $past(coolVariable))
		else $error("lower output alarm not on cooling side");
	AST_SAMPLE_PULSE: assert property (@(posedge mclk)
		disable iff (!rst_n)
		ce && tick_ff |=> !tick_ff)
		else $error("sampling strobe wider than one cycle");

	// per-channel type register, comparison and delay
	pae_code_t [NCH-1:0] type_ff, nxt_type;
	logic [NCH-1:0]      rearm_ff, nxt_rearm;

	generate
		for (genvar ch = 0; ch < NCH; ch++) begin : gCh
			always_comb begin
				nxt_type[ch]  = type_ff[ch];
				nxt_rearm[ch] = 1'b0;
				// refused codes leave the old type in force
				if (cfgTypeWr[ch] && codeOk(cfgTypeCode, ch)) begin
					nxt_type[ch]  = cfgTypeCode;
					nxt_rearm[ch] = 1'b1;
				end
			end

			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					type_ff[ch]  <= `PAE_T_DEFAULT;
					rearm_ff[ch] <= 1'b1;
				end else if (ce) begin
					type_ff[ch]  <= nxt_type[ch];
					rearm_ff[ch] <= nxt_rearm[ch];
				end
			end

			pae_alarm_compare #(
				.W         (W)
			) uCmp (
				.mclk      (mclk),
				.rst_n     (rst_n),
				.ce        (ce),
				.sample    (eval_ff),
				.rearm     (rearm_ff[ch]),
				.alarmType (type_ff[ch]),
				.procVal   (procVal_ff),
				.setPt     (setPt_ff),
				.manHigh   (manHi_ff),
				.manLow    (manLo_ff),
				.thrX      (thrX[ch]),
				.devHigh   (devHigh[ch]),
				.devLow    (devLow[ch]),
				.hyst      (hyst),
				.loopBreak (loop_break_alarm),
				.rateTrip  (rateTrip[ch]),
				.raw       (rawAlarm[ch])
			);

			pae_alarm_delay uDly (
				.mclk      (mclk),
				.rst_n     (rst_n),
				.ce        (ce),
				.secTick   (sec_ff),
				.rawIn     (rawAlarm[ch]),
				.onDelay   (onDelay[ch]),
				.offDelay  (offDelay[ch]),
				.auxOut    (auxOut[ch])
			);

			AST_TYPE_REFUSE: assert property (@(posedge mclk)
				disable iff (!rst_n)
				ce && cfgTypeWr[ch] && !codeOk(cfgTypeCode, ch)
				|=> $stable(type_ff[ch]))
				else $error("refused alarm type was taken");
			AST_TYPE_TAKE: assert property (@(posedge mclk)
				disable iff (!rst_n)
				ce && cfgTypeWr[ch] && codeOk(cfgTypeCode, ch)
				|=> type_ff[ch] == $past(cfgTypeCode) && rearm_ff[ch])
				else $error("valid alarm type not taken");
			// reset value and every accepted write are legal codes
			AST_TYPE_LEGAL: assert property (@(posedge mclk)
				disable iff (!rst_n)
				codeOk(type_ff[ch], ch))
				else $error("alarm type register holds illegal code");
		end
	endgenerate

	assign activeType = type_ff;

	AST_SEC_ON_SAMPLE: assert property (@(posedge mclk)
		disable iff (!rst_n)
		sec_ff |-> tick_ff)
		else $error("second tick off the sampling grid");
	AST_EVAL_AFTER: assert property (@(posedge mclk) disable iff (!rst_n)
		ce && tick_ff |=> eval_ff ##1 !eval_ff)
		else $error("evaluation strobe misplaced");
	AST_ANALOG_VAL: assert property (@(posedge mclk)
		disable iff (!rst_n)
		ce && tick_ff && analogSel
		|=> procVal_ff >= $signed(`PAE_SCALE_MIN) &&
			procVal_ff <= $signed(`PAE_SCALE_MAX))
		else $error("scaled value out of display range");
endmodule : pae_alarm_evaluator

/* hdl/pae_params.svh */
`ifndef PAE_PARAMS_SVH
`define PAE_PARAMS_SVH
`define PAE_CLK_NS         10
`define PAE_SAMPLE_NS      50000000
`define PAE_SAMPLE_CYC     (`PAE_SAMPLE_NS / `PAE_CLK_NS)
`define PAE_SECOND_NS      1000000000
`define PAE_SAMPLES_PER_S  (`PAE_SECOND_NS / `PAE_SAMPLE_NS)
`define PAE_DELAY_MAX      10'h3E7
`define PAE_T_OFF          5'h00
`define PAE_T_BAND_OUT     5'h01
`define PAE_T_DEV_HI       5'h02
`define PAE_T_DEV_LO       5'h03
`define PAE_T_BAND_IN      5'h04
`define PAE_T_BAND_OUT_SB  5'h05
`define PAE_T_DEV_HI_SB    5'h06
`define PAE_T_DEV_LO_SB    5'h07
`define PAE_T_ABS_HI       5'h08
`define PAE_T_ABS_LO       5'h09
`define PAE_T_ABS_HI_SB    5'h0A
`define PAE_T_ABS_LO_SB    5'h0B
`define PAE_T_LOOP_BREAK   5'h0C
`define PAE_T_RATE         5'h0D
`define PAE_T_SP_HI        5'h0E
`define PAE_T_SP_LO        5'h0F
`define PAE_T_MV_HI        5'h10
`define PAE_T_MV_LO        5'h11
`define PAE_T_DEFAULT      5'h02
`define PAE_IN_ANALOG_LO   5'h19
`define PAE_IN_ANALOG_HI   5'h1D
`define PAE_SCALE_MIN      16'hF831
`define PAE_SCALE_MAX      16'h270F
`define PAE_FRAC_BITS      16
`endif

/* hdl/pae_pkg.sv */
package pae_pkg;
	typedef logic [4:0]  pae_code_t;
	typedef logic [9:0]  pae_secs_t;
	typedef enum logic [0:0] {
		DLY_IDLE,
		DLY_COUNT
	} pae_dly_e;
endpackage : pae_pkg

/* hdl/pae_alarm_delay.sv */
`timescale 1ns/1ns
`include "pae_params.svh"
module pae_alarm_delay
	import pae_pkg::*;
(
	input  wire logic      mclk,
	input  wire logic      rst_n,
	input  wire logic      ce,
	input  wire logic      secTick,
	input  wire logic      rawIn,
	input  wire pae_secs_t onDelay,
	input  wire pae_secs_t offDelay,
	output logic           auxOut
);
	pae_dly_e  state_ff, nxt_state;
	pae_secs_t cnt_ff,   nxt_cnt;
	logic      out_ff,   nxt_out;
	pae_secs_t target;

	always_comb begin
		target = rawIn ? onDelay : offDelay;
		if (target > `PAE_DELAY_MAX) begin
			target = `PAE_DELAY_MAX;
		end
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_out   = out_ff;
		unique case (state_ff)
			DLY_IDLE: begin
				if (rawIn != out_ff) begin
					if (target == '0) begin
						nxt_out = rawIn;
					end else begin
						nxt_state = DLY_COUNT;
						nxt_cnt   = '0;
					end
				end
			end
			DLY_COUNT: begin
				// raw fell back before expiry: drop the count, restart later
				if (rawIn == out_ff) begin
					nxt_state = DLY_IDLE;
				end else if (secTick) begin
					if (cnt_ff + 10'h001 >= target) begin
						nxt_out   = rawIn;
						nxt_state = DLY_IDLE;
					end else begin
						nxt_cnt = cnt_ff + 10'h001;
					end
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= DLY_IDLE;
			cnt_ff   <= '0;
			out_ff   <= 1'b0;
		end else if (ce) begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			out_ff   <= nxt_out;
		end
	end

	assign auxOut = out_ff;

	sequence sZeroDiff;
		ce && state_ff == DLY_IDLE && rawIn != out_ff && target == '0;
	endsequence
	AST_DLY_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
		sZeroDiff |=> out_ff == $past(rawIn))
		else $error("zero delay did not follow raw");
	AST_DLY_CAUSE: assert property (@(posedge mclk) disable iff (!rst_n)
		$changed(out_ff) |-> $past(rawIn) == out_ff && $past(ce))
		else $error("aux changed without raw cause");
endmodule : pae_alarm_delay

/* hdl/pae_alarm_compare.sv */
`timescale 1ns/1ns
`include "pae_params.svh"
module pae_alarm_compare
	import pae_pkg::*;
#(
	parameter int W = 16
)(
	input  wire logic                mclk,
	input  wire logic                rst_n,
	input  wire logic                ce,
	input  wire logic                sample,
	input  wire logic                rearm,
	input  wire pae_code_t           alarmType,
	input  wire logic signed [W-1:0] procVal,
	input  wire logic signed [W-1:0] setPt,
	input  wire logic signed [W-1:0] manHigh,
	input  wire logic signed [W-1:0] manLow,
	input  wire logic signed [W-1:0] thrX,
	input  wire logic signed [W-1:0] devHigh,
	input  wire logic signed [W-1:0] devLow,
	input  wire logic        [W-1:0] hyst,
	input  wire logic                loopBreak,
	input  wire logic                rateTrip,
	output logic                     raw
);
	localparam int X = W + 2;
	logic signed [X-1:0] procE, setE, thrE, hiE, loE, dev;
	logic overlap, cond, standby, raw_ff, nxt_raw, arm_ff, nxt_arm;

	always_comb begin
		procE = X'(procVal);
		setE  = X'(setPt);
		thrE  = X'(thrX);
		hiE   = setE + X'(devHigh);
		loE   = setE + X'(devLow);
		dev   = procE - setE;
		// hysteresis bands meet when the limits sit no more than 2*hyst apart
		overlap = (hiE - loE) <= $signed({1'b0, hyst, 1'b0});
		standby = 1'b0;
		unique case (alarmType)
			`PAE_T_BAND_OUT, `PAE_T_BAND_OUT_SB:
				cond = !overlap && (procE > hiE || procE < loE);
			`PAE_T_DEV_HI, `PAE_T_DEV_HI_SB:  cond = dev >= thrE;
			`PAE_T_DEV_LO, `PAE_T_DEV_LO_SB:  cond = -dev >= thrE;
			`PAE_T_BAND_IN:   cond = procE >= loE && procE <= hiE;
			`PAE_T_ABS_HI, `PAE_T_ABS_HI_SB:  cond = procVal > thrX;
			`PAE_T_ABS_LO, `PAE_T_ABS_LO_SB:  cond = procVal < thrX;
			`PAE_T_LOOP_BREAK: cond = loopBreak;
			`PAE_T_RATE:      cond = rateTrip;
			`PAE_T_SP_HI:     cond = setPt > thrX;
			`PAE_T_SP_LO:     cond = setPt < thrX;
			`PAE_T_MV_HI:     cond = manHigh > thrX;
			`PAE_T_MV_LO:     cond = manLow < thrX;
			default:          cond = 1'b0;
		endcase
		unique case (alarmType)
			`PAE_T_BAND_OUT_SB, `PAE_T_DEV_HI_SB, `PAE_T_DEV_LO_SB,
			`PAE_T_ABS_HI_SB, `PAE_T_ABS_LO_SB: standby = 1'b1;
			default: standby = 1'b0;
		endcase
		// standby: suppress until the condition is once seen clear
		nxt_arm = arm_ff;
		nxt_raw = raw_ff;
		if (rearm) begin
			nxt_arm = 1'b1;
		end else if (sample) begin
			if (!cond) begin
				nxt_arm = 1'b0;
			end
			nxt_raw = cond && !(standby && arm_ff);
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			raw_ff <= 1'b0;
			arm_ff <= 1'b1;
		end else if (ce) begin
			raw_ff <= nxt_raw;
			arm_ff <= nxt_arm;
		end
	end

	assign raw = raw_ff;

	AST_CODE0_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
		ce && sample && !rearm && alarmType == `PAE_T_OFF |=> !raw_ff)
		else $error("disabled alarm went active");
	AST_DEV_HI: assert property (@(posedge mclk) disable iff (!rst_n)
		ce && sample && !rearm && alarmType == `PAE_T_DEV_HI
		|=> raw_ff == ($past(dev) >= $past(thrE)))
		else $error("upper deviation result wrong");
	AST_ABS_LO: assert property (@(posedge mclk) disable iff (!rst_n)
		ce && sample && !rearm && alarmType == `PAE_T_ABS_LO
		|=> raw_ff == ($past(procVal) < $past(thrX)))
		else $error("absolute lower result wrong");
	AST_OVERLAP: assert property (@(posedge mclk) disable iff (!rst_n)
		ce && sample && !rearm && overlap && alarmType == `PAE_T_BAND_OUT
		|=> !raw_ff)
		else $error("band alarm active with overlap");
	AST_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
		!(ce && sample) |=> $stable(raw_ff))
		else $error("result changed between samples");
endmodule : pae_alarm_compare

/* tb/pae_alarm_evaluator_tb_top.sv */
`timescale 1ns/1ns
`include "pae_params.svh"
`define CHK(g, e, m) begin \
	comparisons++; \
	if ((g) !== (e)) begin \
		badCount++; \
		$display("BAD %0t %s", $time, m); \
	end \
end
module pae_alarm_evaluator_tb_top
	import pae_pkg::*;
;
	localparam int NCH  = 2;
	localparam int W    = 16;
	localparam int SCYC = 20;
	localparam int SSMP = 2;
	logic                     mclk;
	logic                     rst_n;
	logic [NCH-1:0]           cfgTypeWr;
	pae_code_t                cfgTypeCode;
	logic [NCH-1:0][W-1:0]    thrX;
	logic [NCH-1:0][W-1:0]    devHigh;
	logic [NCH-1:0][W-1:0]    devLow;
	logic [NCH-1:0][9:0]      onDelay;
	logic [NCH-1:0][9:0]      offDelay;
	logic [W-1:0]             hyst;
	pae_code_t                inputType;
	logic signed [W-1:0]      tempIn;
	logic [15:0]              analogIn;
	logic signed [W-1:0]      scaleLow;
	logic signed [W-1:0]      scaleHigh;
	logic [1:0]               decimalsIn;
	logic signed [W-1:0]      setPtIn;
	logic signed [W-1:0]      manIn;
	logic signed [W-1:0]      coolVariable;
	logic                     heatCool;
	logic                     loopBreak;
	logic [NCH-1:0]           rateTrip;
	logic [NCH-1:0]           auxOut;
	logic [NCH-1:0]           rawAlarm;
	pae_code_t [NCH-1:0]      activeType;
	logic signed [W-1:0]      procOut;
	logic [1:0]               procDecimals;
	logic                     sampleTick;
	int                       badCount;
	int                       comparisons;

	pae_alarm_evaluator #(.NCH(NCH), .W(W), .SAMPLE_CYC(SCYC),
		.SEC_SMP(SSMP)) dut_u (
		.mclk(mclk), .rst_n(rst_n), .ce(1'b1),
		.cfgTypeWr(cfgTypeWr), .cfgTypeCode(cfgTypeCode),
		.thrX(thrX), .devHigh(devHigh), .devLow(devLow),
		.onDelay(onDelay), .offDelay(offDelay), .hyst(hyst),
		.inputType(inputType), .tempIn(tempIn), .analogIn(analogIn),
		.scaleLow(scaleLow), .scaleHigh(scaleHigh),
		.decimalsIn(decimalsIn), .set_point(setPtIn),
		.manipulated_variable(manIn), .coolVariable(coolVariable),
		.heatCool(heatCool), .loop_break_alarm(loopBreak),
		.rateTrip(rateTrip), .auxOut(auxOut), .rawAlarm(rawAlarm),
		.activeType(activeType), .process_value(procOut),
		.procDecimals(procDecimals), .sampleTick(sampleTick));

	always #5 mclk = ~mclk;

	task automatic summarize;
		if (badCount == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize

	// waits for the next tick; run calls it twice so the second one surely latched the new inputs
	task automatic waitSample;
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while (sampleTick !== 1'b1 && n < 200);
		if (n >= 200) `CHK(1'b0, 1'b1, "sample tick missing")
	endtask : waitSample

	task automatic setType(input int ch, input pae_code_t code);
		@(posedge mclk);
		cfgTypeWr <= NCH'(1 << ch);
		cfgTypeCode <= code;
		@(posedge mclk);
		cfgTypeWr <= '0;
		@(posedge mclk);
		#1;
	endtask : setType

	// rewrites the type only on change, a write rearms standby
	task automatic run(input int ch, input pae_code_t code,
		input logic [W-1:0] procV, input logic [W-1:0] setV,
		input logic [W-1:0] x, input logic exp, input string msg);
		if (activeType[ch] !== code) setType(ch, code);
		@(posedge mclk);
		tempIn <= procV;
		setPtIn <= setV;
		thrX[ch] <= x;
		waitSample();
		waitSample();
		repeat (3) @(posedge mclk);
		#1;
		`CHK(rawAlarm[ch], exp, msg)
		@(posedge mclk);
		#1;
		`CHK(auxOut[ch], exp, msg)
	endtask : run

	task automatic tReset;
		`CHK(activeType[0], `PAE_T_DEFAULT, "type 0 reset")
		`CHK(activeType[1], `PAE_T_DEFAULT, "type 1 reset")
		`CHK(auxOut, 2'h0, "aux reset")
	endtask : tReset

	task automatic tConfig;
		setType(1, `PAE_T_LOOP_BREAK);
		`CHK(activeType[1], `PAE_T_DEFAULT, "code 12 ch1")
		setType(0, 5'h12);
		`CHK(activeType[0], `PAE_T_DEFAULT, "code 18")
		setType(0, `PAE_T_LOOP_BREAK);
		`CHK(activeType[0], `PAE_T_LOOP_BREAK, "code 12 ch0")
	endtask : tConfig

	task automatic tCompare;
		run(0, 5'h02, 16'h006E, 16'h0064, 16'h000A, 1'b1, "dev hi");
		run(0, 5'h02, 16'h006D, 16'h0064, 16'h000A, 1'b0, "dev hi");
		run(0, 5'h02, 16'h005F, 16'h0064, 16'hFFF6, 1'b1, "neg X");
		run(0, 5'h03, 16'h005A, 16'h0064, 16'h000A, 1'b1, "dev lo");
		run(0, 5'h00, 16'h00C8, 16'h0064, 16'h000A, 1'b0, "off");
		devHigh[0] <= 16'h0014;
		devLow[0] <= 16'hFFEC;
		run(0, 5'h01, 16'h007D, 16'h0064, 16'h0000, 1'b1, "band");
		run(0, 5'h01, 16'h0073, 16'h0064, 16'h0000, 1'b0, "band");
		run(0, 5'h04, 16'h0073, 16'h0064, 16'h0000, 1'b1, "in");
		run(0, 5'h04, 16'h007D, 16'h0064, 16'h0000, 1'b0, "in");
		devLow[0] <= 16'h0014;
		run(0, 5'h01, 16'h007D, 16'h0064, 16'h0000, 1'b0, "ovl");
		run(0, 5'h08, 16'h0033, 16'h0000, 16'h0032, 1'b1, "abs");
		run(0, 5'h08, 16'h0032, 16'h0000, 16'h0032, 1'b0, "abs");
		run(0, 5'h09, 16'h0032, 16'h0000, 16'h0032, 1'b0, "abs");
		run(0, 5'h09, 16'h0031, 16'h0000, 16'h0032, 1'b1, "abs");
		run(0, 5'h0E, 16'h0000, 16'h003C, 16'h0032, 1'b1, "sp");
		run(0, 5'h0F, 16'h0000, 16'h0028, 16'h0032, 1'b1, "sp");
		manIn <= 16'h003C;
		coolVariable <= 16'h0028;
		run(0, 5'h10, 16'h0000, 16'h0000, 16'h0032, 1'b1, "mv");
		run(0, 5'h11, 16'h0000, 16'h0000, 16'h0032, 1'b0, "mv");
		heatCool <= 1'b1;
		run(0, 5'h11, 16'h0000, 16'h0000, 16'h0032, 1'b1, "cool");
		loopBreak <= 1'b1;
		run(0, 5'h0C, 16'h0000, 16'h0000, 16'h0000, 1'b1, "loop");
		rateTrip <= 2'h2;
		run(1, 5'h0D, 16'h0000, 16'h0000, 16'h0000, 1'b1, "rate");
	endtask : tCompare

	task automatic tStandby;
		// condition already true at arming: held off until seen false
		run(1, 5'h06, 16'h0078, 16'h0064, 16'h000A, 1'b0, "sb");
		run(1, 5'h06, 16'h0064, 16'h0064, 16'h000A, 1'b0, "sb");
		run(1, 5'h06, 16'h0078, 16'h0064, 16'h000A, 1'b1, "sb");
		run(1, 5'h0A, 16'h0078, 16'h0000, 16'h000A, 1'b0, "sb");
		devHigh[1] <= 16'h0014;
		devLow[1] <= 16'hFFEC;
		run(1, 5'h05, 16'h0078, 16'h0000, 16'h0000, 1'b0, "sb");
	endtask : tStandby

	task automatic tAnalog;
		scaleLow <= 16'h0000;
		scaleHigh <= 16'h03E8;
		analogIn <= 16'h8000;
		decimalsIn <= 2'h2;
		for (int c = 25; c <= 29; c++) begin
			@(posedge mclk);
			inputType <= 5'(c);
			waitSample();
			waitSample();
			repeat (2) @(posedge mclk);
			#1;
			`CHK(procOut, 16'h01F4, "analog scale")
			`CHK(procDecimals, 2'h2, "analog decimals")
		end
		@(posedge mclk);
		inputType <= 5'h00;
	endtask : tAnalog

	task automatic tDelay;
		int n;
		run(0, 5'h08, 16'h000A, 16'h0000, 16'h0032, 1'b0, "dly");
		@(posedge mclk);
		onDelay[0] <= 10'h002;
		offDelay[0] <= 10'h002;
		tempIn <= 16'h0064;
		n = 0;
		do begin @(posedge mclk); #1; n++; end
			while (rawAlarm[0] !== 1'b1 && n < 200);
		@(posedge mclk);
		#1;
		`CHK(auxOut[0], 1'b0, "on delay early")
		n = 1;
		do begin @(posedge mclk); #1; n++; end
			while (auxOut[0] !== 1'b1 && n < 200);
		`CHK(n >= 38 && n <= 82, 1'b1, "on delay span")
		// drop raw for one sample only: off count must restart
		@(posedge mclk);
		tempIn <= 16'h000A;
		n = 0;
		do begin @(posedge mclk); #1; n++; end
			while (rawAlarm[0] !== 1'b0 && n < 200);
		@(posedge mclk);
		tempIn <= 16'h0064;
		repeat (120) @(posedge mclk);
		#1;
		`CHK(auxOut[0], 1'b1, "off delay restart")
		@(posedge mclk);
		onDelay[0] <= 10'h000;
		offDelay[0] <= 10'h000;
	endtask : tDelay

	initial begin
		#200000;
		badCount++;
		summarize();
	end

	initial begin
		mclk = 1'b0;
		badCount = 0;
		comparisons = 0;
		rst_n <= 1'b0;
		cfgTypeWr <= '0;
		cfgTypeCode <= 5'h00;
		thrX <= '0;
		devHigh <= '0;
		devLow <= '0;
		onDelay <= '0;
		offDelay <= '0;
		hyst <= 16'h0001;
		inputType <= 5'h00;
		tempIn <= 16'h0000;
		analogIn <= 16'h0000;
		scaleLow <= 16'h0000;
		scaleHigh <= 16'h0000;
		decimalsIn <= 2'h0;
		setPtIn <= 16'h0000;
		manIn <= 16'h0000;
		coolVariable <= 16'h0000;
		heatCool <= 1'b0;
		loopBreak <= 1'b0;
		rateTrip <= 2'h0;
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		#1;
		tReset();
		tConfig();
		tCompare();
		tStandby();
		tAnalog();
		tDelay();
		summarize();
	end
endmodule : pae_alarm_evaluator_tb_top
